/* verilog/crr_defs.svh */
// register offsets, field positions, reset values and timing for the result and regulation bank
`ifndef CRR_DEFS_SVH
`define CRR_DEFS_SVH
// ==========================================================================
// register offsets
`define CRR_A_VOUT_HI   8'h1C
`define CRR_A_VOUT_LO   8'h1D
`define CRR_A_VBAT_HI   8'h1E
`define CRR_A_VBAT_LO   8'h1F
`define CRR_A_IBAT_HI   8'h20
`define CRR_A_IBAT_LO   8'h21
`define CRR_A_TSBUS_HI  8'h22
`define CRR_A_TSBUS_LO  8'h23
`define CRR_A_TSBAT_HI  8'h24
`define CRR_A_TSBAT_LO  8'h25
`define CRR_A_TDIE_HI   8'h26
`define CRR_A_TDIE_LO   8'h27
`define CRR_A_TSBUS_THR 8'h28
`define CRR_A_TSBAT_THR 8'h29
`define CRR_A_DIE_ALM   8'h2A
`define CRR_A_CTRL      8'h2B
`define CRR_A_THRSTAT   8'h2C
`define CRR_A_FLAGMASK  8'h2D
`define CRR_A_FILTER    8'h2E
// ==========================================================================
// reset values
`define CRR_RST_ZERO    8'h00
`define CRR_RST_TS_THR  8'h15
`define CRR_RST_DIE_ALM 8'hC8
// ==========================================================================
// field positions
`define CRR_CTRL_SS_LSB  5
`define CRR_CTRL_REG_EN  4
`define CRR_CTRL_OVP_DIS 3
`define CRR_CTRL_UCP     2
`define CRR_CTRL_RSNS    1
`define CRR_CTRL_PD      0
`define CRR_THR_I_LSB    6
`define CRR_THR_V_LSB    4
`define CRR_FLAG_LSB     4
`define CRR_FILT_LSB     3
// ==========================================================================
// analog scaling
`define CRR_DIE_ALM_OFS  9'h032
`define CRR_IOFS_BASE    10'h0C8
`define CRR_IOFS_STEP    10'h064
`define CRR_VOFS_BASE    8'h32
`define CRR_VOFS_STEP    8'h32
`define CRR_UCP_R_LO     10'h12C
`define CRR_UCP_F_LO     10'h096
`define CRR_UCP_R_HI     10'h1F4
`define CRR_UCP_F_HI     10'h0FA
`define CRR_RSNS_LO_MOHM 16'sd2
`define CRR_RSNS_HI_MOHM 16'sd5
// ==========================================================================
// timing
`define CRR_CLK_KHZ      20000
`define CRR_TICK_US      500
`define CRR_PD_US        400000
`define CRR_SS1_US       12500
`define CRR_SS2_US       25000
`define CRR_SS3_US       50000
`define CRR_SS4_US       100000
`define CRR_SS5_US       400000
`define CRR_SS6_US       1500000
`define CRR_SS7_US       100000000
`endif

/* verilog/crr_pkg.sv */
// types shared by the result and regulation register bank
package crr_pkg;
   // converter channels
   typedef enum logic [2:0] {
      CRR_CH_VOUT,
      CRR_CH_VBAT,
      CRR_CH_IBAT,
      CRR_CH_TSBUS,
      CRR_CH_TSBAT,
      CRR_CH_TDIE
   } crr_chan_t;

   // one finished conversion
   typedef struct packed {
      logic        valid;
      crr_chan_t   chan;
      logic [15:0] value;
   } crr_conv_t;

   // live analog status, same order as the status bits
   typedef struct packed {
      logic cell_voltage_loop_live;
      logic cell_current_loop_live;
      logic drop_overvoltage_live;
      logic output_overvoltage_live;
   } crr_live_t;

   // soft-start timer
   typedef enum logic {
      CRR_SS_IDLE,
      CRR_SS_RUN
   } crr_ss_state_t;
endpackage

/* verilog/crr_regs.sv */
// result, threshold and regulation registers with event flags and interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "crr_defs.svh"

module crr_regs
   import crr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES   = `CRR_TICK_US * `CRR_CLK_KHZ / 1000,
   parameter int unsigned SS_LONG_TICKS = `CRR_SS7_US / `CRR_TICK_US
) (
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire crr_conv_t  conv_i,
   input  wire crr_live_t  live_i,
   input  wire logic       bus_current_above_i,
   input  wire logic       soft_start_begin_i,
   input  wire logic       regulation_timeout_i,
   output logic            die_heat_alarm_o,
   output logic            bus_thermistor_fault_o,
   output logic            cell_thermistor_fault_o,
   output logic            regulation_enable_o,
   output logic            output_overvoltage_protect_o,
   output logic      [9:0] bus_ucp_rise_ma_o,
   output logic      [9:0] bus_ucp_fall_ma_o,
   output logic            sense_resistor_select_o,
   output logic      [9:0] cell_current_loop_offset_o,
   output logic      [7:0] cell_voltage_loop_offset_o,
   output logic            input_pulldown_o,
   output logic            soft_start_fail_o,
   output logic      [1:0] filter_time_o,
   output logic            interrupt_out_low_o,
   output logic            interrupt_out_low_oe_o
);

   localparam int unsigned NCH      = 6;
   localparam logic [9:0]  PD_TICKS = 10'(`CRR_PD_US / `CRR_TICK_US);

   // ========================================================================
   // helpers
   // ------------------------------------------------------------------------

   // pack a conversion into its high and low register bytes
   function automatic logic [15:0] fmt(input crr_chan_t ch, input logic [15:0] v);
      logic [15:0] r;
      r = v;
      case (ch)
         CRR_CH_TSBUS, CRR_CH_TSBAT: r = {v[15], 5'h00, v[9:0]};
         CRR_CH_TDIE:                r = {v[15], 6'h00, v[8:0]};
         default:                    r = v;
      endcase
      return r;
   endfunction

   // soft-start length in ticks
   function automatic logic [17:0] ss_ticks(input logic [2:0] sel);
      logic [17:0] t;
      t = 18'h0_0000;
      case (sel)
         3'h1:    t = 18'(`CRR_SS1_US / `CRR_TICK_US);
         3'h2:    t = 18'(`CRR_SS2_US / `CRR_TICK_US);
         3'h3:    t = 18'(`CRR_SS3_US / `CRR_TICK_US);
         3'h4:    t = 18'(`CRR_SS4_US / `CRR_TICK_US);
         3'h5:    t = 18'(`CRR_SS5_US / `CRR_TICK_US);
         3'h6:    t = 18'(`CRR_SS6_US / `CRR_TICK_US);
         3'h7:    t = 18'(SS_LONG_TICKS);
         default: t = 18'h0_0000;
      endcase
      return t;
   endfunction

   // ========================================================================
   // state
   // ------------------------------------------------------------------------
   logic [15:0]   res_q [NCH];
   logic [15:0]   res_d [NCH];
   logic [7:0]    shd_q [NCH];
   logic [7:0]    shd_d [NCH];
   logic [NCH-1:0] arm_q, arm_d;
   logic [7:0]    bthr_q, bthr_d, cthr_q, cthr_d, dalm_q, dalm_d;
   logic [7:0]    ctrl_q, ctrl_d;
   logic [1:0]    ioff_q, ioff_d, voff_q, voff_d, filt_q, filt_d;
   logic [3:0]    mask_q, mask_d, flag_q, flag_d;
   crr_live_t     live_m_q, live_s_q, live_p_q;
   logic          bus_m_q, bus_s_q;
   logic [13:0]   div_q, div_d;
   logic          tick;
   crr_ss_state_t ss_q, ss_d;
   logic [17:0]   ss_cnt_q, ss_cnt_d;
   logic [9:0]    pd_cnt_q, pd_cnt_d;
   logic [7:0]    rdata_d;
   logic          fail_d, dalm_out_d, bflt_d, cflt_d;
   logic          is_res, res_hi;
   logic [2:0]    res_ch;
   logic [7:0]    res_off;
   logic signed [15:0] ibat_s;

   // ========================================================================
   // host access decode
   // ------------------------------------------------------------------------
   assign res_off = reg_addr_i - `CRR_A_VOUT_HI;
   assign is_res  = (reg_addr_i >= `CRR_A_VOUT_HI) && (reg_addr_i <= `CRR_A_TDIE_LO);
   assign res_ch  = res_off[3:1];
   assign res_hi  = ~res_off[0];
   assign ibat_s  = $signed(conv_i.value);

   // ========================================================================
   // result registers and high/low pairing
   // ------------------------------------------------------------------------
   always_comb begin
      logic [15:0] v;
      v = conv_i.value;
      for (int i = 0; i < NCH; i++) begin
         res_d[i] = res_q[i];
         shd_d[i] = shd_q[i];
      end
      arm_d = arm_q;
      // current sense voltage divided by resistor value
      if (conv_i.chan == CRR_CH_IBAT) begin
         v = ctrl_q[`CRR_CTRL_RSNS] ? 16'(ibat_s / `CRR_RSNS_HI_MOHM)
                                    : 16'(ibat_s / `CRR_RSNS_LO_MOHM);
      end
      // both bytes change together from one conversion
      if (conv_i.valid && (conv_i.chan <= CRR_CH_TDIE)) begin
         res_d[conv_i.chan] = fmt(conv_i.chan, v);
      end
      // high read freezes the low byte until it is read
      if (reg_rd_i && is_res) begin
         if (res_hi) begin
            shd_d[res_ch] = res_q[res_ch][7:0];
            arm_d[res_ch] = 1'b1;
         end else begin
            arm_d[res_ch] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            res_q[i] <= 16'h0000;
            shd_q[i] <= 8'h00;
         end
         arm_q <= '0;
      end else begin
         res_q <= res_d;
         shd_q <= shd_d;
         arm_q <= arm_d;
      end
   end

   // ========================================================================
   // configuration registers
   // ------------------------------------------------------------------------
   always_comb begin
      bthr_d = bthr_q;
      cthr_d = cthr_q;
      dalm_d = dalm_q;
      ctrl_d = ctrl_q;
      ioff_d = ioff_q;
      voff_d = voff_q;
      mask_d = mask_q;
      filt_d = filt_q;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `CRR_A_TSBUS_THR: bthr_d = reg_wdata_i;
            `CRR_A_TSBAT_THR: cthr_d = reg_wdata_i;
            `CRR_A_DIE_ALM:   dalm_d = reg_wdata_i;
            `CRR_A_CTRL:      ctrl_d = reg_wdata_i;
            `CRR_A_THRSTAT: begin
               ioff_d = reg_wdata_i[`CRR_THR_I_LSB +: 2];
               voff_d = reg_wdata_i[`CRR_THR_V_LSB +: 2];
            end
            `CRR_A_FLAGMASK:  mask_d = reg_wdata_i[3:0];
            `CRR_A_FILTER:    filt_d = reg_wdata_i[`CRR_FILT_LSB +: 2];
            default: ;
         endcase
      end
      // timeout drops regulation even against a same-cycle write
      if (regulation_timeout_i) begin
         ctrl_d[`CRR_CTRL_REG_EN] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bthr_q <= `CRR_RST_TS_THR;
         cthr_q <= `CRR_RST_TS_THR;
         dalm_q <= `CRR_RST_DIE_ALM;
         ctrl_q <= `CRR_RST_ZERO;
         ioff_q <= 2'h0;
         voff_q <= 2'h0;
         mask_q <= 4'h0;
         filt_q <= 2'h0;
      end else begin
         bthr_q <= bthr_d;
         cthr_q <= cthr_d;
         dalm_q <= dalm_d;
         ctrl_q <= ctrl_d;
         ioff_q <= ioff_d;
         voff_q <= voff_d;
         mask_q <= mask_d;
         filt_q <= filt_d;
      end
   end

   // ========================================================================
   // status synchronisers and event flags
   // ------------------------------------------------------------------------
   always_comb begin
      // read clears, a new event in the same cycle still sets
      flag_d = flag_q;
      if (reg_rd_i && (reg_addr_i == `CRR_A_FLAGMASK)) begin
         flag_d = 4'h0;
      end
      flag_d = flag_d | (live_s_q & ~live_p_q);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         live_m_q <= '0;
         live_s_q <= '0;
         live_p_q <= '0;
         bus_m_q  <= 1'b0;
         bus_s_q  <= 1'b0;
         flag_q   <= 4'h0;
      end else begin
         live_m_q <= live_i;
         live_s_q <= live_m_q;
         live_p_q <= live_s_q;
         bus_m_q  <= bus_current_above_i;
         bus_s_q  <= bus_m_q;
         flag_q   <= flag_d;
      end
   end

   // ========================================================================
   // tick divider, soft-start timer and input pulldown
   // ------------------------------------------------------------------------
   assign tick = (div_q == 14'(TICK_CYCLES - 1));

   always_comb begin
      div_d    = tick ? 14'h0000 : div_q + 14'h0001;
      ss_d     = ss_q;
      ss_cnt_d = ss_cnt_q;
      fail_d   = 1'b0;
      pd_cnt_d = pd_cnt_q;
      case (ss_q)
         CRR_SS_IDLE: begin
            if (soft_start_begin_i && (ctrl_q[`CRR_CTRL_SS_LSB +: 3] != 3'h0)) begin
               ss_cnt_d = ss_ticks(ctrl_q[`CRR_CTRL_SS_LSB +: 3]);
               ss_d     = CRR_SS_RUN;
            end
         end
         CRR_SS_RUN: begin
            if (ss_cnt_q == 18'h0_0000) begin
               fail_d = ~bus_s_q;
               ss_d   = CRR_SS_IDLE;
            end else if (tick) begin
               ss_cnt_d = ss_cnt_q - 18'h0_0001;
            end
         end
         default: ss_d = CRR_SS_IDLE;
      endcase
      // pulldown starts when the enable bit goes from 0 to 1
      if (ctrl_d[`CRR_CTRL_PD] && !ctrl_q[`CRR_CTRL_PD]) begin
         pd_cnt_d = PD_TICKS;
      end else if (tick && (pd_cnt_q != 10'h000)) begin
         pd_cnt_d = pd_cnt_q - 10'h001;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q    <= 14'h0000;
         ss_q     <= CRR_SS_IDLE;
         ss_cnt_q <= 18'h0_0000;
         pd_cnt_q <= 10'h000;
      end else begin
         div_q    <= div_d;
         ss_q     <= ss_d;
         ss_cnt_q <= ss_cnt_d;
         pd_cnt_q <= pd_cnt_d;
      end
   end

   // ========================================================================
   // read data and threshold comparisons
   // ------------------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (is_res) begin
         if (res_hi) begin
            rdata_d = res_q[res_ch][15:8];
         end else begin
            rdata_d = arm_q[res_ch] ? shd_q[res_ch] : res_q[res_ch][7:0];
         end
      end else begin
         case (reg_addr_i)
            `CRR_A_TSBUS_THR: rdata_d = bthr_q;
            `CRR_A_TSBAT_THR: rdata_d = cthr_q;
            `CRR_A_DIE_ALM:   rdata_d = dalm_q;
            `CRR_A_CTRL:      rdata_d = ctrl_q;
            `CRR_A_THRSTAT:   rdata_d = {ioff_q, voff_q, live_s_q};
            `CRR_A_FLAGMASK:  rdata_d = {flag_q, mask_q};
            `CRR_A_FILTER:    rdata_d = {3'h0, filt_q, 3'h0};
            default:          rdata_d = 8'h00;
         endcase
      end
      // thermistor below its level is a fault; a level step is two result steps
      bflt_d = res_q[CRR_CH_TSBUS][15] ||
               (res_q[CRR_CH_TSBUS][9:0] < {1'b0, bthr_q, 1'b0});
      cflt_d = res_q[CRR_CH_TSBAT][15] ||
               (res_q[CRR_CH_TSBAT][9:0] < {1'b0, cthr_q, 1'b0});
      // die code counts from 5 degrees, alarm level from 30 degrees
      dalm_out_d = !res_q[CRR_CH_TDIE][15] &&
                   (res_q[CRR_CH_TDIE][8:0] >= ({1'b0, dalm_q} + `CRR_DIE_ALM_OFS));
   end

   // ========================================================================
   // registered outputs
   // ------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o                  <= 8'h00;
         die_heat_alarm_o             <= 1'b0;
         bus_thermistor_fault_o       <= 1'b0;
         cell_thermistor_fault_o      <= 1'b0;
         regulation_enable_o          <= 1'b0;
         output_overvoltage_protect_o <= 1'b1;
         bus_ucp_rise_ma_o            <= `CRR_UCP_R_LO;
         bus_ucp_fall_ma_o            <= `CRR_UCP_F_LO;
         sense_resistor_select_o      <= 1'b0;
         cell_current_loop_offset_o   <= `CRR_IOFS_BASE;
         cell_voltage_loop_offset_o   <= `CRR_VOFS_BASE;
         input_pulldown_o             <= 1'b0;
         soft_start_fail_o            <= 1'b0;
         filter_time_o                <= 2'h0;
         interrupt_out_low_o          <= 1'b0;
         interrupt_out_low_oe_o       <= 1'b0;
      end else begin
         reg_rdata_o                  <= reg_rd_i ? rdata_d : 8'h00;
         die_heat_alarm_o             <= dalm_out_d;
         bus_thermistor_fault_o       <= bflt_d;
         cell_thermistor_fault_o      <= cflt_d;
         regulation_enable_o          <= ctrl_q[`CRR_CTRL_REG_EN];
         output_overvoltage_protect_o <= ~ctrl_q[`CRR_CTRL_OVP_DIS];
         bus_ucp_rise_ma_o            <= ctrl_q[`CRR_CTRL_UCP] ? `CRR_UCP_R_HI
                                                               : `CRR_UCP_R_LO;
         bus_ucp_fall_ma_o            <= ctrl_q[`CRR_CTRL_UCP] ? `CRR_UCP_F_HI
                                                               : `CRR_UCP_F_LO;
         sense_resistor_select_o      <= ctrl_q[`CRR_CTRL_RSNS];
         cell_current_loop_offset_o   <= `CRR_IOFS_BASE + 10'(ioff_q) * `CRR_IOFS_STEP;
         cell_voltage_loop_offset_o   <= `CRR_VOFS_BASE + 8'(voff_q) * `CRR_VOFS_STEP;
         input_pulldown_o             <= (pd_cnt_q != 10'h000);
         soft_start_fail_o            <= fail_d;
         filter_time_o                <= filt_q;
         interrupt_out_low_o          <= 1'b0;
         interrupt_out_low_oe_o       <= |(flag_q & ~mask_q);
      end
   end

endmodule // crr_regs
`default_nettype wire

/* tb/crr_regs_checker.sv */
// assertions on the ports of the result and regulation register bank
`timescale 1ns/1ps
`default_nettype none
module crr_regs_checker
   import crr_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       regulation_timeout_i,
   input wire logic       regulation_enable_o,
   input wire logic       output_overvoltage_protect_o,
   input wire logic [9:0] bus_ucp_rise_ma_o,
   input wire logic [9:0] bus_ucp_fall_ma_o,
   input wire logic [9:0] cell_current_loop_offset_o,
   input wire logic [7:0] cell_voltage_loop_offset_o,
   input wire logic       soft_start_fail_o,
   input wire logic       interrupt_out_low_o,
   input wire logic       interrupt_out_low_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================================================
   // write cycles to the control and threshold registers
   sequence s_ctrl_wr;
      reg_wr_i && reg_addr_i == 8'h2B;
   endsequence
   sequence s_thr_wr;
      reg_wr_i && reg_addr_i == 8'h2C;
   endsequence
   // all four interrupt masks set in one write
   sequence s_mask_all_wr;
      reg_wr_i && reg_addr_i == 8'h2D && reg_wdata_i[3:0] == 4'hF;
   endsequence
   // ==========================================================================
   // outputs follow what was written two edges earlier
   a_ovp_follows_write: assert property (s_ctrl_wr |-> ##2
      output_overvoltage_protect_o == !$past(reg_wdata_i[3], 2)) else $error("ovp enable wrong");
   a_reg_en_follows: assert property ((s_ctrl_wr ##0 !regulation_timeout_i) |-> ##2
      regulation_enable_o == $past(reg_wdata_i[4], 2)) else $error("regulation enable wrong");
   a_timeout_clears_en: assert property (regulation_timeout_i |-> ##2
      !regulation_enable_o) else $error("timeout left enable set");
   a_ucp_pair_legal: assert property (
      (bus_ucp_rise_ma_o == 10'h12C && bus_ucp_fall_ma_o == 10'h096) ||
      (bus_ucp_rise_ma_o == 10'h1F4 && bus_ucp_fall_ma_o == 10'h0FA)) else $error("ucp pair");
   a_ioff_follows: assert property (s_thr_wr |-> ##2 cell_current_loop_offset_o ==
      10'h0C8 + 10'h064 * $past(reg_wdata_i[7:6], 2)) else $error("current offset wrong");
   a_voff_follows: assert property (s_thr_wr |-> ##2 cell_voltage_loop_offset_o ==
      8'h32 + 8'h32 * $past(reg_wdata_i[5:4], 2)) else $error("voltage offset wrong");
   a_fail_one_pulse: assert property (soft_start_fail_o |=>
      !soft_start_fail_o) else $error("fail pulse too long");
   a_irq_data_low: assert property (!interrupt_out_low_o) else $error("irq data high");
   a_mask_blocks_irq: assert property (s_mask_all_wr |-> ##2
      !interrupt_out_low_oe_o) else $error("masked interrupt still driven");
endmodule // crr_regs_checker
bind crr_regs crr_regs_checker u_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
   .reg_wdata_i, .regulation_timeout_i, .regulation_enable_o, .output_overvoltage_protect_o,
   .bus_ucp_rise_ma_o, .bus_ucp_fall_ma_o, .cell_current_loop_offset_o,
   .cell_voltage_loop_offset_o, .soft_start_fail_o, .interrupt_out_low_o,
   .interrupt_out_low_oe_o);
`default_nettype wire

/* tb/crr_host_model.sv */
// host side of the register port: one-cycle write and read strobes
`timescale 1ns/1ps
`default_nettype none
module crr_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o
);
   // ==========================================================================
   // idle bus before the first transfer
   initial begin
      reg_addr_o = 8'hFF;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'hA5;
   end
   // released lines show the inverse so stale values never pass
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge sys_clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   // read data is taken one cycle after the strobe edge
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge sys_clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
   endtask
endmodule // crr_host_model
`default_nettype wire

/* tb/tb_crr_regs.sv */
// self-checking bench for the result and regulation register bank
`timescale 1ns/1ps
`default_nettype none
module tb_crr_regs
   import crr_pkg::*;
;
   logic       clk, rst, wr, rd, above, ss_go, rto, alarm, fbus, fcell;
   logic       reg_en, prot, rsel, pd, fail, oe;
   logic [7:0] addr, wdata, rdata, voff;
   logic [9:0] urise, ufall, ioff;
   logic [1:0] filt;
   crr_conv_t  conv;
   crr_live_t  live;
   int         err_total = 0;
   int         samples_checked = 0;
   crr_host_model host (.sys_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
   crr_regs #(.TICK_CYCLES(4), .SS_LONG_TICKS(10)) dut (.sys_clk_i(clk), .sys_rst_i(rst),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .conv_i(conv), .live_i(live), .bus_current_above_i(above),
      .soft_start_begin_i(ss_go), .regulation_timeout_i(rto), .die_heat_alarm_o(alarm),
      .bus_thermistor_fault_o(fbus), .cell_thermistor_fault_o(fcell),
      .regulation_enable_o(reg_en), .output_overvoltage_protect_o(prot),
      .bus_ucp_rise_ma_o(urise), .bus_ucp_fall_ma_o(ufall), .sense_resistor_select_o(rsel),
      .cell_current_loop_offset_o(ioff), .cell_voltage_loop_offset_o(voff),
      .input_pulldown_o(pd), .soft_start_fail_o(fail), .filter_time_o(filt),
      .interrupt_out_low_o(), .interrupt_out_low_oe_o(oe));
   // ==========================================================================
   // shared helpers
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.get(a, d);
      chk(d, exp);
   endtask
   task automatic cv(input crr_chan_t c, input logic [15:0] v);
      @(negedge clk);
      conv = '{1'b1, c, v};
      @(negedge clk);
      conv.valid = 1'b0;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================================
   // scenarios
   task automatic t_reset;
      for (int a = 8'h1B; a <= 8'h2F; a++)
         rdchk(8'(a), a == 8'h2A ? 8'hC8 : (a == 8'h28 || a == 8'h29) ? 8'h15 : 8'h00);
      chk({prot, urise, ufall}, {1'b1, 10'h12C, 10'h096});
      $display("reset values done");
   endtask
   task automatic t_conv;
      crr_chan_t   ch[6] = '{CRR_CH_VOUT, CRR_CH_VBAT, CRR_CH_IBAT, CRR_CH_TSBUS,
                             CRR_CH_TSBAT, CRR_CH_TDIE};
      logic [15:0] vin[6] = '{16'hC1A5, 16'h7F01, 16'h07D0, 16'hFFFD, 16'h002A, 16'h00FA};
      logic [15:0] ex[6] = '{16'hC1A5, 16'h7F01, 16'h03E8, 16'h83FD, 16'h002A, 16'h00FA};
      for (int i = 0; i < 6; i++) begin
         cv(ch[i], vin[i]);
         rdchk(8'h1C + 8'(2 * i), ex[i][15:8]);
         rdchk(8'h1D + 8'(2 * i), ex[i][7:0]);
      end
      chk({alarm, fbus, fcell}, 3'b110);
      host.put(8'h2A, 8'hC9);
      cv(CRR_CH_TSBAT, 16'h0029);
      wait_n(3);
      chk({alarm, fcell}, 2'b01);
      host.put(8'h2B, 8'h02);
      cv(CRR_CH_IBAT, 16'h1388);
      rdchk(8'h20, 8'h03);
      cv(CRR_CH_IBAT, 16'h0000);
      rdchk(8'h21, 8'hE8);
      rdchk(8'h21, 8'h00);
      chk(rsel, 1'b1);
      $display("conversions done");
   endtask
   task automatic t_ctrl;
      host.put(8'h2B, 8'h1C);
      wait_n(2);
      chk({reg_en, prot, urise, ufall}, {2'b10, 10'h1F4, 10'h0FA});
      @(negedge clk) rto = 1'b1;
      @(negedge clk) rto = 1'b0;
      wait_n(2);
      chk(reg_en, 1'b0);
      rdchk(8'h2B, 8'h0C);
      for (int k = 0; k < 4; k++) begin
         host.put(8'h2C, {2'(k), 2'(k), 4'hF});
         wait_n(2);
         chk({ioff, voff}, {10'(200 + 100 * k), 8'(50 + 50 * k)});
         rdchk(8'h2C, {2'(k), 2'(k), 4'h0});
      end
      host.put(8'h2E, 8'hFF);
      rdchk(8'h2E, 8'h18);
      chk(filt, 2'b11);
      $display("control done");
   endtask
   task automatic t_irq;
      live = 4'b0100;
      wait_n(6);
      chk(oe, 1'b1);
      rdchk(8'h2D, 8'h40);
      wait_n(2);
      chk(oe, 1'b0);
      host.put(8'h2D, 8'h0F);
      live = 4'b0010;
      wait_n(6);
      chk(oe, 1'b0);
      rdchk(8'h2C, 8'hF2);
      rdchk(8'h2D, 8'h2F);
      rdchk(8'h2D, 8'h0F);
      $display("events done");
   endtask
   task automatic t_timer;
      int tk[8] = '{0, 25, 50, 100, 200, 800, 3000, 10};
      int n;
      int sel;
      // last pass runs the 25-tick timeout (setting 1) with bus current above the level
      for (int k = 0; k < 9; k++) begin
         above = (k == 8);
         sel = (k == 8) ? 1 : k;
         host.put(8'h2B, {3'(sel), 5'h00});
         n = 0;
         @(negedge clk) ss_go = 1'b1;
         @(negedge clk) ss_go = 1'b0;
         while (fail !== 1'b1 && n < 4 * tk[sel] + 40) begin
            @(negedge clk);
            n++;
         end
         chk(fail, k != 0 && k != 8);
         if (k != 0 && k != 8) chk(n >= 4 * tk[k] - 8 && n <= 4 * tk[k] + 8, 1'b1);
      end
      host.put(8'h2B, 8'h01);
      wait_n(3150);
      chk(pd, 1'b1);
      wait_n(60);
      chk(pd, 1'b0);
      $display("timers done");
   endtask
   // ==========================================================================
   // clock, stimulus sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      conv = '0;
      live = '0;
      above = 1'b0;
      ss_go = 1'b0;
      rto = 1'b0;
      wait_n(3);
      rst = 1'b0;
      t_reset();
      t_conv();
      t_ctrl();
      t_irq();
      t_timer();
      complete_run();
   end
   initial begin
      #2_000_000;
      err_total++;
      complete_run();
   end
endmodule // tb_crr_regs
`default_nettype wire
